// File: rtl/pmc_consts.vh
`ifndef PMC_CONSTS_VH
`define PMC_CONSTS_VH
// ----------------------------------------
// Mode encodings.
// ----------------------------------------
`define MODE_RUN 3'h0
`define MODE_LPRUN 3'h1
`define MODE_WAIT 3'h2
`define MODE_LPWAIT 3'h3
`define MODE_STOP3 3'h4
`define MODE_STOP2 3'h5
// ----------------------------------------
// Regulator state encodings.
// ----------------------------------------
`define REG_FULL 2'h0
`define REG_STANDBY 2'h1
`define REG_PARTIAL 2'h2
// ----------------------------------------
// Clock source configuration encodings.
// ----------------------------------------
`define CLK_RUN_CFG 2'h0
`define CLK_BYPASS_LP 2'h1
`define CLK_STOPPED 2'h2
// ----------------------------------------
// Wakeup pin synchroniser depth.
// ----------------------------------------
`define SYNC_STAGES 2
`endif

// File: rtl/pin_sync.v
`timescale 1ns/1ps
// ----------------------------------------
// Two stage synchroniser for a pin level.
// ----------------------------------------
module pin_sync (
  input wire CLK,
  input wire RST_N,
  input wire D,
  output wire Q
);
  reg meta_r;
  reg sync_r;
  always @(posedge CLK) begin
    if (!RST_N) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end else begin
      meta_r <= D;
      sync_r <= meta_r;
    end
  end
  assign Q = sync_r;
endmodule // pin_sync

// File: rtl/mode_flags.v
`timescale 1ns/1ps
// ----------------------------------------
// Mutually exclusive request bits.
// ----------------------------------------
module mode_flags (
  input wire CLK,
  input wire RST_N,
  input wire lpr_wr,
  input wire lpr_val,
  input wire ppd_wr,
  input wire ppd_val,
  input wire hw_clr_lpr,
  output reg lpr_r,
  output reg ppd_r
);
  reg lpr_nxt;
  reg ppd_nxt;
  always @* begin
    lpr_nxt = lpr_r;
    ppd_nxt = ppd_r;
    if (lpr_wr && !(lpr_val && ppd_r)) begin
      lpr_nxt = lpr_val;
    end
    if (ppd_wr && !(ppd_val && lpr_r)) begin
      ppd_nxt = ppd_val;
    end
    if (lpr_wr && ppd_wr && lpr_val && ppd_val) begin
      lpr_nxt = lpr_r;
      ppd_nxt = ppd_r;
    end
    if (hw_clr_lpr) begin
      lpr_nxt = 1'b0;
    end
  end
  always @(posedge CLK) begin
    if (!RST_N) begin
      lpr_r <= 1'b0;
      ppd_r <= 1'b0;
    end else begin
      lpr_r <= lpr_nxt;
      ppd_r <= ppd_nxt;
    end
  end
endmodule // mode_flags

// File: rtl/power_mode_controller.v
// What this block does
// - Both detect enables keep regulator full in stop3.
// - Stop2 request with both detect enables gives stop3.
// - Stop2 request with debug enabled gives stop3.
// - Never stop2 directly from low power run.
// - Partial powerdown and low power run exclusive.
// - Stop in low power run enters stop3.
// - Reset ends stop3 into normal run.
// - Wake-to-run clear: interrupt returns low power run.
// - Wake-to-run set: interrupt gives run, clears low power run request.
// - Low power run only under its enabling conditions.
// - Wait stops CPU clock, peripherals keep running.
// - Wait in low power run enters low power wait.
// - Stop2 needs all its conditions; regulator partial.
// - Stop2 powers down all but real-time counter.
// - Debug enable written only by debug commands.
// - Low wakeup pin wakes regulator, starts power-on reset.
// - After stop2 wake, flag and latch until acknowledge.
`timescale 1ns/1ps
`include "pmc_consts.vh"
module power_mode_controller (
  input wire CLK,
  input wire RST_N,
  input wire LOW_VOLT_DETECT_ENABLE,
  input wire LOW_VOLT_DETECT_STOP_ENABLE,
  input wire STOP_INSTRUCTION_ENABLE,
  input wire LOW_POWER_WAKE_TO_RUN,
  input wire LPR_WRITE,
  input wire LPR_WRITE_VALUE,
  input wire PPD_WRITE,
  input wire PPD_WRITE_VALUE,
  input wire POWERDOWN_ACKNOWLEDGE,
  input wire DEBUG_CMD_WRITE,
  input wire DEBUG_CMD_VALUE,
  input wire STOP_EXEC,
  input wire WAIT_EXEC,
  input wire WAKE_INTERRUPT,
  input wire WAKE_RESET,
  input wire STOP2_WAKEUP_PIN,
  output reg [2:0] MODE,
  output reg [1:0] REGULATOR_STATE,
  output reg [1:0] CLOCK_SOURCE_CFG,
  output reg CPU_CLOCK_ON,
  output reg PERIPH_CLOCK_ON,
  output reg PERIPH_CLOCK_LOW_SPEED,
  output reg DEBUG_CLOCK_ON,
  output reg CORE_POWER_ON,
  output reg RTC_POWER_ON,
  output reg PIN_STATE_LATCH,
  output reg POWER_ON_RESET_REQ,
  output wire LOW_POWER_RUN_REQUEST,
  output wire PARTIAL_POWERDOWN_REQUEST,
  output reg LOW_POWER_RUN_STATUS,
  output reg POWERDOWN_WAKE_FLAG,
  output reg DEBUG_MODE_ENABLE
);
// ----------------------------------------
// Request bits and synchronised pin.
// ----------------------------------------
  wire wake_pin_s;
  wire lpr_q;
  wire ppd_q;
  reg hw_clr_lpr;
  pin_sync u_sync (
    .CLK(CLK),
    .RST_N(RST_N),
    .D(STOP2_WAKEUP_PIN),
    .Q(wake_pin_s)
  );
  mode_flags u_flags (
    .CLK(CLK),
    .RST_N(RST_N),
    .lpr_wr(LPR_WRITE),
    .lpr_val(LPR_WRITE_VALUE),
    .ppd_wr(PPD_WRITE),
    .ppd_val(PPD_WRITE_VALUE),
    .hw_clr_lpr(hw_clr_lpr),
    .lpr_r(lpr_q),
    .ppd_r(ppd_q)
  );
  assign LOW_POWER_RUN_REQUEST = lpr_q;
  assign PARTIAL_POWERDOWN_REQUEST = ppd_q;
// ----------------------------------------
// Mode conditions.
// ----------------------------------------
  wire lvd_stop = LOW_VOLT_DETECT_ENABLE && LOW_VOLT_DETECT_STOP_ENABLE;
  wire lp_ok = lpr_q && !DEBUG_MODE_ENABLE && !lvd_stop && !ppd_q;
  wire stop2_ok = ppd_q && !lpr_q && !DEBUG_MODE_ENABLE && !lvd_stop;
  wire stop_go = STOP_EXEC && STOP_INSTRUCTION_ENABLE;
// ----------------------------------------
// Mode decoding helpers.
// ----------------------------------------
  function is_low_power;
    input [2:0] m;
    begin
      is_low_power = (m == `MODE_LPRUN) || (m == `MODE_LPWAIT);
    end
  endfunction
  function is_stopped;
    input [2:0] m;
    begin
      is_stopped = (m == `MODE_STOP3) || (m == `MODE_STOP2);
    end
  endfunction
  reg [2:0] mode_r;
  reg [2:0] mode_nxt;
  reg lp_before_r;
  reg lp_before_nxt;
  reg clr_lpr_nxt;
// ----------------------------------------
// Debug enable, written only by debug commands.
// ----------------------------------------
  always @(posedge CLK) begin
    if (!RST_N) begin
      DEBUG_MODE_ENABLE <= 1'b0;
    end else if (DEBUG_CMD_WRITE) begin
      DEBUG_MODE_ENABLE <= DEBUG_CMD_VALUE;
    end
  end
// ----------------------------------------
// Mode state machine.
// ----------------------------------------
  always @* begin
    mode_nxt = mode_r;
    lp_before_nxt = lp_before_r;
    clr_lpr_nxt = 1'b0;
    case (mode_r)
      `MODE_RUN: begin
        if (stop_go) begin
          lp_before_nxt = 1'b0;
          if (stop2_ok) begin
            mode_nxt = `MODE_STOP2;
          end else begin
            mode_nxt = `MODE_STOP3;
          end
        end else if (WAIT_EXEC) begin
          mode_nxt = `MODE_WAIT;
        end else if (lp_ok) begin
          mode_nxt = `MODE_LPRUN;
        end
      end
      `MODE_LPRUN: begin
        if (!lp_ok) begin
          mode_nxt = `MODE_RUN;
        end else if (stop_go) begin
          lp_before_nxt = 1'b1;
          mode_nxt = `MODE_STOP3;
        end else if (WAIT_EXEC) begin
          mode_nxt = `MODE_LPWAIT;
        end
      end
      `MODE_WAIT: begin
        if (WAKE_INTERRUPT || WAKE_RESET) begin
          mode_nxt = `MODE_RUN;
        end
      end
      `MODE_LPWAIT: begin
        if (WAKE_RESET) begin
          mode_nxt = `MODE_RUN;
        end else if (WAKE_INTERRUPT) begin
          if (LOW_POWER_WAKE_TO_RUN) begin
            mode_nxt = `MODE_RUN;
            clr_lpr_nxt = 1'b1;
          end else begin
            mode_nxt = `MODE_LPRUN;
          end
        end
      end
      `MODE_STOP3: begin
        if (WAKE_RESET) begin
          mode_nxt = `MODE_RUN;
          clr_lpr_nxt = 1'b1;
        end else if (WAKE_INTERRUPT) begin
          if (lp_before_r && !LOW_POWER_WAKE_TO_RUN) begin
            mode_nxt = `MODE_LPRUN;
          end else begin
            mode_nxt = `MODE_RUN;
            clr_lpr_nxt = lp_before_r;
          end
        end
      end
      `MODE_STOP2: begin
        if (!wake_pin_s) begin
          mode_nxt = `MODE_RUN;
        end
      end
      default: begin
        mode_nxt = `MODE_RUN;
      end
    endcase
  end
  always @* begin
    hw_clr_lpr = clr_lpr_nxt;
  end
  always @(posedge CLK) begin
    if (!RST_N) begin
      mode_r <= `MODE_RUN;
      lp_before_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      lp_before_r <= lp_before_nxt;
    end
  end
// ----------------------------------------
// Powerdown wake flag and pin latch.
// ----------------------------------------
  reg pdf_r;
  wire stop2_wake = (mode_r == `MODE_STOP2) && !wake_pin_s;
  always @(posedge CLK) begin
    if (!RST_N) begin
      pdf_r <= 1'b0;
    end else if (stop2_wake) begin
      pdf_r <= 1'b1;
    end else if (POWERDOWN_ACKNOWLEDGE) begin
      pdf_r <= 1'b0;
    end
  end
// ----------------------------------------
// Registered outputs.
// ----------------------------------------
  always @(posedge CLK) begin
    if (!RST_N) begin
      MODE <= `MODE_RUN;
      REGULATOR_STATE <= `REG_FULL;
      CLOCK_SOURCE_CFG <= `CLK_RUN_CFG;
      CPU_CLOCK_ON <= 1'b1;
      PERIPH_CLOCK_ON <= 1'b1;
      PERIPH_CLOCK_LOW_SPEED <= 1'b0;
      DEBUG_CLOCK_ON <= 1'b0;
      CORE_POWER_ON <= 1'b1;
      RTC_POWER_ON <= 1'b1;
      PIN_STATE_LATCH <= 1'b0;
      POWER_ON_RESET_REQ <= 1'b0;
      LOW_POWER_RUN_STATUS <= 1'b0;
      POWERDOWN_WAKE_FLAG <= 1'b0;
    end else begin
      MODE <= mode_r;
      LOW_POWER_RUN_STATUS <= is_low_power(mode_r);
      POWERDOWN_WAKE_FLAG <= pdf_r;
      PIN_STATE_LATCH <= pdf_r || (mode_r == `MODE_STOP2);
      POWER_ON_RESET_REQ <= stop2_wake;
      DEBUG_CLOCK_ON <= DEBUG_MODE_ENABLE;
      CPU_CLOCK_ON <= (mode_r == `MODE_RUN) || (mode_r == `MODE_LPRUN);
      PERIPH_CLOCK_ON <= !is_stopped(mode_r);
      PERIPH_CLOCK_LOW_SPEED <= is_low_power(mode_r);
      CORE_POWER_ON <= (mode_r != `MODE_STOP2);
      RTC_POWER_ON <= 1'b1;
      case (mode_r)
        `MODE_LPRUN, `MODE_LPWAIT: begin
          REGULATOR_STATE <= `REG_STANDBY;
          CLOCK_SOURCE_CFG <= `CLK_BYPASS_LP;
        end
        `MODE_STOP3: begin
          if (lvd_stop || DEBUG_MODE_ENABLE) begin
            REGULATOR_STATE <= `REG_FULL;
          end else begin
            REGULATOR_STATE <= `REG_STANDBY;
          end
          if (DEBUG_MODE_ENABLE) begin
            CLOCK_SOURCE_CFG <= `CLK_RUN_CFG;
          end else begin
            CLOCK_SOURCE_CFG <= `CLK_STOPPED;
          end
        end
        `MODE_STOP2: begin
          REGULATOR_STATE <= `REG_PARTIAL;
          CLOCK_SOURCE_CFG <= `CLK_STOPPED;
        end
        default: begin
          REGULATOR_STATE <= `REG_FULL;
          CLOCK_SOURCE_CFG <= `CLK_RUN_CFG;
        end
      endcase
    end
  end
endmodule // power_mode_controller

// File: dv/pmc_chk.sv
`timescale 1ns/1ps
`include "pmc_consts.vh"
// ----------------------------------------
// Port checker.
// ----------------------------------------
module pmc_chk (
  input wire CLK,
  input wire RST_N,
  input wire LOW_VOLT_DETECT_ENABLE,
  input wire LOW_VOLT_DETECT_STOP_ENABLE,
  input wire LOW_POWER_WAKE_TO_RUN,
  input wire POWERDOWN_ACKNOWLEDGE,
  input wire STOP_EXEC,
  input wire WAKE_INTERRUPT,
  input wire STOP2_WAKEUP_PIN,
  input wire [2:0] MODE,
  input wire [1:0] REGULATOR_STATE,
  input wire [1:0] CLOCK_SOURCE_CFG,
  input wire CPU_CLOCK_ON,
  input wire CORE_POWER_ON,
  input wire RTC_POWER_ON,
  input wire POWER_ON_RESET_REQ,
  input wire LOW_POWER_RUN_REQUEST,
  input wire PARTIAL_POWERDOWN_REQUEST,
  input wire POWERDOWN_WAKE_FLAG
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire low_volt_detector = LOW_VOLT_DETECT_ENABLE && LOW_VOLT_DETECT_STOP_ENABLE;
  sequence s_irq;
    MODE == `MODE_STOP3 && LOW_POWER_RUN_REQUEST && WAKE_INTERRUPT;
  endsequence
  sequence s_to_run;
    !LOW_POWER_RUN_REQUEST ##1 MODE == `MODE_RUN;
  endsequence
  a_req_excl: assert property (!(LOW_POWER_RUN_REQUEST && PARTIAL_POWERDOWN_REQUEST))
    else $error("both requests set");
  a_lvd_no_stop2: assert property (STOP_EXEC && low_volt_detector |-> ##2 MODE != `MODE_STOP2)
    else $error("stop2 with detect");
  a_lp_no_stop2: assert property (MODE == `MODE_LPRUN && STOP_EXEC |->
    ##2 MODE != `MODE_STOP2)
    else $error("stop2 from lprun");
  a_lvd_reg_full: assert property (MODE == `MODE_STOP3 && low_volt_detector |->
    REGULATOR_STATE == `REG_FULL)
    else $error("regulator not full");
  a_lprun_cfg: assert property (MODE == `MODE_LPRUN |->
    REGULATOR_STATE == `REG_STANDBY && CLOCK_SOURCE_CFG == `CLK_BYPASS_LP)
    else $error("lprun config");
  a_wait_clocks: assert property (MODE == `MODE_WAIT |->
    !CPU_CLOCK_ON && CLOCK_SOURCE_CFG == `CLK_RUN_CFG)
    else $error("wait clocks");
  a_lpwait_state: assert property (MODE == `MODE_LPWAIT |->
    !CPU_CLOCK_ON && REGULATOR_STATE == `REG_STANDBY)
    else $error("lpwait state");
  a_stop2_power: assert property (MODE == `MODE_STOP2 |->
    REGULATOR_STATE == `REG_PARTIAL && !CORE_POWER_ON && RTC_POWER_ON)
    else $error("stop2 power");
  a_wake_run: assert property (s_irq ##0 LOW_POWER_WAKE_TO_RUN |-> ##1 s_to_run)
    else $error("wake to run");
  a_wake_lprun: assert property (s_irq ##0 !LOW_POWER_WAKE_TO_RUN |->
    ##2 MODE == `MODE_LPRUN)
    else $error("wake to lprun");
  a_flag_hold: assert property (POWERDOWN_WAKE_FLAG && !POWERDOWN_ACKNOWLEDGE &&
    !$past(POWERDOWN_ACKNOWLEDGE) |=> POWERDOWN_WAKE_FLAG)
    else $error("flag dropped");
  a_wake_flag_set: assert property (MODE == `MODE_STOP2 && POWER_ON_RESET_REQ |=>
    POWERDOWN_WAKE_FLAG)
    else $error("wake flag not set");
  a_pin_por: assert property ($fell(STOP2_WAKEUP_PIN) && MODE == `MODE_STOP2 |->
    ##[1:6] POWER_ON_RESET_REQ)
    else $error("no power-on reset");
endmodule // pmc_chk
bind power_mode_controller pmc_chk pmc_chk_inst (.*);

// File: dv/power_mode_controller_bench.sv
`timescale 1ns/1ps
`include "pmc_consts.vh"
module power_mode_controller_bench;
  logic CLK, RST_N, LOW_VOLT_DETECT_ENABLE, LOW_VOLT_DETECT_STOP_ENABLE;
  logic STOP_INSTRUCTION_ENABLE, LOW_POWER_WAKE_TO_RUN, LPR_WRITE, LPR_WRITE_VALUE;
  logic PPD_WRITE, PPD_WRITE_VALUE, POWERDOWN_ACKNOWLEDGE, DEBUG_CMD_WRITE;
  logic DEBUG_CMD_VALUE, STOP_EXEC, WAIT_EXEC, WAKE_INTERRUPT, WAKE_RESET, STOP2_WAKEUP_PIN;
  logic [2:0] MODE;
  logic [1:0] REGULATOR_STATE, CLOCK_SOURCE_CFG;
  logic CPU_CLOCK_ON, PERIPH_CLOCK_ON, PERIPH_CLOCK_LOW_SPEED, DEBUG_CLOCK_ON, CORE_POWER_ON;
  logic RTC_POWER_ON, PIN_STATE_LATCH, POWER_ON_RESET_REQ, LOW_POWER_RUN_REQUEST;
  logic PARTIAL_POWERDOWN_REQUEST, LOW_POWER_RUN_STATUS, POWERDOWN_WAKE_FLAG, DEBUG_MODE_ENABLE;
  logic [7:0] stb;
  logic [3:0] lvl;
  int failures = 0;
  int n_checks = 0;
  localparam int lowrun = 0, pdown = 1, dbg = 2, stp = 3, wt = 4, irq = 5, rstw = 6, ack = 7;
  assign {POWERDOWN_ACKNOWLEDGE, WAKE_RESET, WAKE_INTERRUPT, WAIT_EXEC, STOP_EXEC,
    DEBUG_CMD_WRITE, PPD_WRITE, LPR_WRITE} = stb;
  assign {LOW_VOLT_DETECT_ENABLE, LOW_VOLT_DETECT_STOP_ENABLE, STOP_INSTRUCTION_ENABLE,
    LOW_POWER_WAKE_TO_RUN} = lvl;
  power_mode_controller power_mode_controller_inst (.*);
  // ----------------------------------------
  // Tasks.
  // ----------------------------------------
  task results;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [3:0] s, input logic [3:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task pulse(input int k, input logic v, input logic [3:0] l);
    @(posedge CLK);
    lvl <= l;
    {LPR_WRITE_VALUE, PPD_WRITE_VALUE, DEBUG_CMD_VALUE} <= {3{v}};
    stb <= 8'h01 << k;
    @(posedge CLK);
    stb <= 8'h00;
    #1;
  endtask
  task wm(input logic [2:0] m);
    int i;
    for (i = 0; i < 20 && MODE !== m; i++)
      @(posedge CLK) #1;
    chk(MODE, m);
    if (MODE !== m)
      results();
  endtask
  // ----------------------------------------
  // Clock and sequence.
  // ----------------------------------------
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  initial begin
    RST_N = 1'b0;
    stb = 8'h00;
    lvl = 4'h8;
    {LPR_WRITE_VALUE, PPD_WRITE_VALUE, DEBUG_CMD_VALUE, STOP2_WAKEUP_PIN} = 4'h1;
    repeat (5) @(posedge CLK);
    RST_N <= 1'b1;
    pulse(pdown, 1, 4'ha);
    pulse(lowrun, 1, 4'ha);
    chk(LOW_POWER_RUN_REQUEST, 0);
    pulse(pdown, 0, 4'ha);
    pulse(lowrun, 1, 4'ha);
    wm(`MODE_LPRUN);
    chk(LOW_POWER_RUN_STATUS, 1);
    pulse(pdown, 1, 4'ha);
    chk(PARTIAL_POWERDOWN_REQUEST, 0);
    pulse(wt, 0, 4'ha);
    wm(`MODE_LPWAIT);
    chk(PERIPH_CLOCK_LOW_SPEED, 1);
    pulse(irq, 0, 4'ha);
    wm(`MODE_LPRUN);
    pulse(stp, 0, 4'ha);
    wm(`MODE_STOP3);
    chk(REGULATOR_STATE, `REG_STANDBY);
    pulse(irq, 0, 4'ha);
    wm(`MODE_LPRUN);
    pulse(stp, 0, 4'ha);
    wm(`MODE_STOP3);
    pulse(irq, 0, 4'hb);
    wm(`MODE_RUN);
    chk(LOW_POWER_RUN_STATUS, 0);
    chk(LOW_POWER_RUN_REQUEST, 0);
    pulse(lowrun, 1, 4'ha);
    wm(`MODE_LPRUN);
    pulse(stp, 0, 4'ha);
    wm(`MODE_STOP3);
    pulse(rstw, 0, 4'ha);
    wm(`MODE_RUN);
    chk(LOW_POWER_RUN_REQUEST, 0);
    pulse(wt, 0, 4'ha);
    wm(`MODE_WAIT);
    chk(PERIPH_CLOCK_ON, 1);
    chk(CPU_CLOCK_ON, 0);
    pulse(irq, 0, 4'ha);
    wm(`MODE_RUN);
    pulse(pdown, 1, 4'he);
    pulse(stp, 0, 4'he);
    wm(`MODE_STOP3);
    chk(REGULATOR_STATE, `REG_FULL);
    pulse(irq, 0, 4'he);
    wm(`MODE_RUN);
    pulse(dbg, 1, 4'ha);
    chk(DEBUG_MODE_ENABLE, 1);
    pulse(stp, 0, 4'ha);
    wm(`MODE_STOP3);
    chk(DEBUG_CLOCK_ON, 1);
    pulse(irq, 0, 4'ha);
    wm(`MODE_RUN);
    pulse(dbg, 0, 4'ha);
    pulse(stp, 0, 4'h8);
    repeat (4) @(posedge CLK);
    #1;
    chk(MODE, `MODE_RUN);
    pulse(stp, 0, 4'ha);
    wm(`MODE_STOP2);
    chk(CORE_POWER_ON, 0);
    @(posedge CLK) STOP2_WAKEUP_PIN <= 1'b0;
    wm(`MODE_RUN);
    chk(PIN_STATE_LATCH, 1);
    chk(POWERDOWN_WAKE_FLAG, 1);
    @(posedge CLK) STOP2_WAKEUP_PIN <= 1'b1;
    pulse(ack, 1, 4'ha);
    @(posedge CLK) #1;
    chk(POWERDOWN_WAKE_FLAG, 0);
    chk(PIN_STATE_LATCH, 0);
    pulse(pdown, 0, 4'ha);
    pulse(lowrun, 1, 4'ha);
    wm(`MODE_LPRUN);
    pulse(lowrun, 0, 4'ha);
    wm(`MODE_RUN);
    chk(LOW_POWER_RUN_STATUS, 0);
    pulse(wt, 0, 4'ha);
    wm(`MODE_WAIT);
    pulse(rstw, 0, 4'ha);
    wm(`MODE_RUN);
    pulse(lowrun, 1, 4'ha);
    wm(`MODE_LPRUN);
    pulse(wt, 0, 4'ha);
    wm(`MODE_LPWAIT);
    pulse(irq, 0, 4'hb);
    wm(`MODE_RUN);
    chk(LOW_POWER_RUN_REQUEST, 0);
    pulse(dbg, 1, 4'ha);
    pulse(lowrun, 1, 4'ha);
    repeat (4) @(posedge CLK);
    #1;
    chk(MODE, `MODE_RUN);
    pulse(dbg, 0, 4'ha);
    wm(`MODE_LPRUN);
    results();
  end
endmodule // power_mode_controller_bench
